// *** rtl/dma_pkg.sv ***
// shared constants and types of the six-channel dma block
package dma_pkg;
  // ==========================================
  // sizes
  localparam int NUM_CH = 6;
  localparam int ADDR_W = 16;
  // ==========================================
  // register map: global index when wbAdr[7:5] is zero
  localparam logic [2:0] CH_GLOBAL = 3'h0;
  localparam logic [2:0] G_ELEM_ADJ0 = 3'h0;
  localparam logic [2:0] G_ELEM_ADJ1 = 3'h1;
  localparam logic [2:0] G_FRM_ADJ0 = 3'h2;
  localparam logic [2:0] G_FRM_ADJ1 = 3'h3;
  localparam logic [2:0] G_CNT_RELOAD = 3'h4;
  localparam logic [2:0] G_FRM_RELOAD = 3'h5;
  localparam logic [2:0] G_PRIO_CTRL = 3'h6;
  // per channel field index, channel n sits at wbAdr[7:5] = n + 1
  localparam logic [2:0] F_SRC = 3'h0;
  localparam logic [2:0] F_DST = 3'h1;
  localparam logic [2:0] F_ELEM = 3'h2;
  localparam logic [2:0] F_SYNC_FRM = 3'h3;
  localparam logic [2:0] F_MODE = 3'h4;
  // ==========================================
  // channel mode control fields
  localparam int M_AUTO_REINIT_BIT = 0;
  localparam int M_IRQ_EN = 1;
  localparam int M_GRAN = 2;
  localparam int M_DWORD = 3;
  localparam int M_ABU = 4;
  localparam int M_SRC_SEL = 5;
  localparam int M_DST_SEL = 7;
  localparam int MODE_W = 9;
  // sync / frame control fields
  localparam int SF_FRM = 0;
  localparam int SF_SYNC = 12;
  // priority and enable control fields
  localparam int P_EN = 0;
  localparam int P_PRI = 8;
  localparam int P_LSEL = 14;
  // ==========================================
  // codes
  localparam logic [3:0] SYNC_NONE = 4'h0;
  localparam logic [3:0] SYNC_SER_FIRST = 4'h1;
  localparam logic [3:0] SYNC_SER_LAST = 4'h6;
  localparam logic [3:0] SYNC_TIMER = 4'hd;
  localparam logic [3:0] SYNC_EXT3 = 4'he;
  localparam logic [1:0] LSEL_SERIAL = 2'h0;
  localparam logic [1:0] LSEL_HALF = 2'h1;
  localparam logic [1:0] LSEL_ALL = 2'h2;
  localparam logic [1:0] STEP_SET0 = 2'h0;
  localparam logic [1:0] STEP_SET1 = 2'h1;
  localparam logic [1:0] STEP_HOLD = 2'h2;
  localparam logic [1:0] STEP_INC = 2'h3;
  // ==========================================
  // reset values and unit steps
  localparam logic [15:0] RST16 = 16'h0000;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [7:0] ONE8 = 8'h01;
  // ==========================================
  // carriers
  typedef struct packed {
    logic line6;
    logic line7;
    logic line10;
    logic line11;
  } irq_lines_t;
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } mem_req_t;
endpackage

// *** rtl/dma_channel_count_index_irq.sv ***
// six-channel dma transfer engine with counters, indexing and irq routing
// Functional notes
// - 8-bit frame count, zero means one frame
// - frame counter drops on last read of frame
// - block end with auto reinit reloads frame count
// - 16-bit element count, all ones is 65536
// - element counter drops after each element read
// - block end with auto reinit reloads element count
// - double word: two halves, one element
// - source and destination steps chosen independently
// - non-final transfers add selected element step
// - final transfer of frame adds frame step
// - irq enable low blocks every interrupt
// - auto buffer: full only, or half and full
// - multi frame, granularity one: each frame end
// - multi frame, granularity zero: block end only
// - 4-bit sync select chooses trigger event
// - each channel raises own irq, 0-3 shared
// - reset line select routes serial irqs only
// - select codes route channels onto shared lines
// - equal priority channels served round robin
module dma_channel_count_index_irq #(
  parameter int NCH = dma_pkg::NUM_CH
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // wishbone register slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // memory master
  output logic memReq,
  output dma_pkg::mem_req_t memCmd,
  input wire logic memAck,
  input wire logic [15:0] memRData,
  // sync events: serial codes 1..6, timer, external pin
  input wire logic [5:0] serialEvt,
  input wire logic timerEvt,
  input wire logic extIrq3Pin,
  // interrupts: serial in {rx2,tx2,rx1,tx1}
  input wire logic [3:0] serialIrq,
  output dma_pkg::irq_lines_t irqLines,
  output logic [5:0] chanIrq
);
  // ==========================================
  // state
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} eng_state_t;
  eng_state_t state_reg;
  logic [15:0] srcAddr_reg [NCH];
  logic [15:0] dstAddr_reg [NCH];
  logic [15:0] elementCount_reg [NCH];
  logic [15:0] elemInit_reg [NCH];
  logic [15:0] syncFrame_reg [NCH];
  logic [dma_pkg::MODE_W-1:0] mode_reg [NCH];
  logic [15:0] elemAdj0_reg, elemAdj1_reg, frmAdj0_reg, frmAdj1_reg;
  logic [15:0] globalCountReload_reg, globalFrameReload_reg, prio_reg;
  logic [5:0] pend_reg;
  logic [2:0] cur_reg, rrPtr_reg;
  logic half_reg, eLast_reg, fLast_reg, halfHit_reg;
  logic [15:0] rdData_reg;
  logic wbAck_reg;
  logic [31:0] wbDatO_reg;
  logic memReq_reg;
  dma_pkg::mem_req_t memCmd_reg;
  logic [5:0] chanIrq_reg;
  logic ext3Meta_reg, ext3Sync_reg, ext3Old_reg;

  // ==========================================
  // helpers
  function automatic logic [15:0] wmerge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  function automatic logic [2:0] pickRr(input logic [5:0] r, input logic [2:0] p);
    int k;
    logic [2:0] res;
    res = p;
    for (int i = NCH; i >= 1; i--) begin
      k = (int'(p) + i) % NCH;
      if (r[k]) res = 3'(k);
    end
    return res;
  endfunction

  function automatic logic [15:0] stepOf(input logic [1:0] sel, input logic last);
    logic [15:0] r;
    r = dma_pkg::RST16;
    case (sel)
      dma_pkg::STEP_SET0: r = last ? frmAdj0_reg : elemAdj0_reg;
      dma_pkg::STEP_SET1: r = last ? frmAdj1_reg : elemAdj1_reg;
      dma_pkg::STEP_HOLD: r = dma_pkg::RST16;
      dma_pkg::STEP_INC: r = dma_pkg::ONE16;
      default: r = dma_pkg::RST16;
    endcase
    return r;
  endfunction

  // ==========================================
  // wishbone decode
  logic wbHit, wbWr, isCh;
  logic [2:0] chSel, wch, fld;
  assign wbHit = wbCyc & wbStb & ~wbAck_reg;
  assign wbWr = wbHit & wbWe;
  assign chSel = wbAdr[7:5];
  assign fld = wbAdr[4:2];
  assign isCh = (chSel != dma_pkg::CH_GLOBAL) && (int'(chSel) <= NCH);
  assign wch = 3'(chSel - 3'h1);

  function automatic logic chWr(input logic [2:0] f);
    return wbWr & isCh & (fld == f);
  endfunction

  function automatic logic gWr(input logic [2:0] f);
    return wbWr & (chSel == dma_pkg::CH_GLOBAL) & (fld == f);
  endfunction

  // ==========================================
  // engine view of the current channel
  logic [dma_pkg::MODE_W-1:0] curMode;
  logic dword, finalHalf, isFinal, lastFrame, rdDone, wrDone, autoRe;
  logic [15:0] curElem;
  logic [5:0] chEn, reqV, hiV;
  logic [2:0] pick;
  logic start;
  assign curMode = mode_reg[cur_reg];
  assign curElem = elementCount_reg[cur_reg];
  assign dword = curMode[dma_pkg::M_DWORD];
  assign finalHalf = ~dword | half_reg;
  assign isFinal = (curElem == dma_pkg::RST16) & finalHalf;
  assign lastFrame = syncFrame_reg[cur_reg][dma_pkg::SF_FRM +: 8] == 8'h00;
  assign rdDone = (state_reg == ST_RD) & memReq_reg & memAck;
  assign wrDone = (state_reg == ST_WR) & memReq_reg & memAck;
  assign autoRe = curMode[dma_pkg::M_AUTO_REINIT_BIT] | curMode[dma_pkg::M_ABU];
  assign chEn = prio_reg[dma_pkg::P_EN +: 6];

  always_comb begin
    for (int c = 0; c < 6; c++) begin
      reqV[c] = 1'b0;
      if (c < NCH) begin
        reqV[c] = chEn[c] &
          ((syncFrame_reg[c][dma_pkg::SF_SYNC +: 4] == dma_pkg::SYNC_NONE) | pend_reg[c]);
      end
    end
  end
  assign hiV = reqV & prio_reg[dma_pkg::P_PRI +: 6];
  assign pick = pickRr((|hiV) ? hiV : reqV, rrPtr_reg);
  assign start = (state_reg == ST_IDLE) & (|reqV);

  // ==========================================
  // sync events
  logic ext3Rise;
  logic [15:0] evtVec;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ext3Meta_reg <= 1'b0;
      ext3Sync_reg <= 1'b0;
      ext3Old_reg <= 1'b0;
    end else begin
      ext3Meta_reg <= extIrq3Pin;
      ext3Sync_reg <= ext3Meta_reg;
      ext3Old_reg <= ext3Sync_reg;
    end
  end
  assign ext3Rise = ext3Sync_reg & ~ext3Old_reg;

  always_comb begin
    evtVec = dma_pkg::RST16;
    evtVec[dma_pkg::SYNC_SER_FIRST +: 6] = serialEvt;
    evtVec[dma_pkg::SYNC_TIMER] = timerEvt;
    evtVec[dma_pkg::SYNC_EXT3] = ext3Rise;
  end

  // pending event per channel, a new event beats the start clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (start && pick == 3'(c)) pend_reg[c] <= 1'b0;
        if (evtVec[syncFrame_reg[c][dma_pkg::SF_SYNC +: 4]]) pend_reg[c] <= 1'b1;
      end
    end
  end

  // ==========================================
  // engine sequencing and memory master
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      cur_reg <= 3'h0;
      rrPtr_reg <= 3'h0;
      half_reg <= 1'b0;
      memReq_reg <= 1'b0;
      memCmd_reg <= '0;
      rdData_reg <= dma_pkg::RST16;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            cur_reg <= pick;
            rrPtr_reg <= pick;
            half_reg <= 1'b0;
            state_reg <= ST_RD;
          end
        end
        ST_RD: begin
          if (!memReq_reg) begin
            memReq_reg <= 1'b1;
            memCmd_reg <= '{we: 1'b0, addr: srcAddr_reg[cur_reg], wdata: dma_pkg::RST16};
          end else if (memAck) begin
            memReq_reg <= 1'b0;
            rdData_reg <= memRData;
            state_reg <= ST_WR;
          end
        end
        ST_WR: begin
          if (!memReq_reg) begin
            memReq_reg <= 1'b1;
            memCmd_reg <= '{we: 1'b1, addr: dstAddr_reg[cur_reg], wdata: rdData_reg};
          end else if (memAck) begin
            memReq_reg <= 1'b0;
            if (dword && !half_reg) begin
              half_reg <= 1'b1;
              state_reg <= ST_RD;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // flags of the read half, used by the write half
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      eLast_reg <= 1'b0;
      fLast_reg <= 1'b0;
      halfHit_reg <= 1'b0;
    end else if (rdDone) begin
      eLast_reg <= isFinal;
      fLast_reg <= lastFrame;
      halfHit_reg <= finalHalf & (curElem == (elemInit_reg[cur_reg] >> 1));
    end
  end

  // ==========================================
  // addresses, bus writes land after engine updates
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < NCH; c++) srcAddr_reg[c] <= dma_pkg::RST16;
    end else begin
      if (rdDone) srcAddr_reg[cur_reg] <= 16'(srcAddr_reg[cur_reg] +
        stepOf(curMode[dma_pkg::M_SRC_SEL +: 2], isFinal));
      if (chWr(dma_pkg::F_SRC)) srcAddr_reg[wch] <= wmerge(srcAddr_reg[wch], wbDatI, wbSel);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < NCH; c++) dstAddr_reg[c] <= dma_pkg::RST16;
    end else begin
      if (wrDone) dstAddr_reg[cur_reg] <= 16'(dstAddr_reg[cur_reg] +
        stepOf(curMode[dma_pkg::M_DST_SEL +: 2], eLast_reg));
      if (chWr(dma_pkg::F_DST)) dstAddr_reg[wch] <= wmerge(dstAddr_reg[wch], wbDatI, wbSel);
    end
  end

  // ==========================================
  // element and frame counters
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < NCH; c++) begin
        elementCount_reg[c] <= dma_pkg::RST16;
        elemInit_reg[c] <= dma_pkg::RST16;
      end
    end else begin
      if (rdDone && finalHalf) begin
        if (!isFinal) begin
          elementCount_reg[cur_reg] <= 16'(curElem - dma_pkg::ONE16);
        end else if (!lastFrame) begin
          elementCount_reg[cur_reg] <= elemInit_reg[cur_reg];
        end else if (autoRe) begin
          elementCount_reg[cur_reg] <= globalCountReload_reg;
          elemInit_reg[cur_reg] <= globalCountReload_reg;
        end
      end
      if (chWr(dma_pkg::F_ELEM)) begin
        elementCount_reg[wch] <= wmerge(elementCount_reg[wch], wbDatI, wbSel);
        elemInit_reg[wch] <= wmerge(elementCount_reg[wch], wbDatI, wbSel);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < NCH; c++) syncFrame_reg[c] <= dma_pkg::RST16;
    end else begin
      if (rdDone && isFinal) begin
        if (!lastFrame) begin
          syncFrame_reg[cur_reg][dma_pkg::SF_FRM +: 8] <=
            8'(syncFrame_reg[cur_reg][dma_pkg::SF_FRM +: 8] - dma_pkg::ONE8);
        end else if (autoRe) begin
          syncFrame_reg[cur_reg][dma_pkg::SF_FRM +: 8] <=
            globalFrameReload_reg[7:0];
        end
      end
      if (chWr(dma_pkg::F_SYNC_FRM)) syncFrame_reg[wch] <= wmerge(syncFrame_reg[wch], wbDatI, wbSel);
    end
  end

  // ==========================================
  // mode and global registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < NCH; c++) mode_reg[c] <= '0;
    end else if (chWr(dma_pkg::F_MODE)) begin
      mode_reg[wch] <= dma_pkg::MODE_W'(wmerge(16'(mode_reg[wch]), wbDatI, wbSel));
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      elemAdj0_reg <= dma_pkg::RST16;
      elemAdj1_reg <= dma_pkg::RST16;
      frmAdj0_reg <= dma_pkg::RST16;
      frmAdj1_reg <= dma_pkg::RST16;
      globalCountReload_reg <= dma_pkg::RST16;
      globalFrameReload_reg <= dma_pkg::RST16;
    end else begin
      if (gWr(dma_pkg::G_ELEM_ADJ0)) elemAdj0_reg <= wmerge(elemAdj0_reg, wbDatI, wbSel);
      if (gWr(dma_pkg::G_ELEM_ADJ1)) elemAdj1_reg <= wmerge(elemAdj1_reg, wbDatI, wbSel);
      if (gWr(dma_pkg::G_FRM_ADJ0)) frmAdj0_reg <= wmerge(frmAdj0_reg, wbDatI, wbSel);
      if (gWr(dma_pkg::G_FRM_ADJ1)) frmAdj1_reg <= wmerge(frmAdj1_reg, wbDatI, wbSel);
      if (gWr(dma_pkg::G_CNT_RELOAD)) begin
        globalCountReload_reg <= wmerge(globalCountReload_reg, wbDatI, wbSel);
      end
      if (gWr(dma_pkg::G_FRM_RELOAD)) begin
        globalFrameReload_reg <= wmerge(globalFrameReload_reg, wbDatI, wbSel);
      end
    end
  end

  // enable cleared at block end without reinit; a bus write lands after it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prio_reg <= dma_pkg::RST16;
    end else begin
      if (wrDone && finalHalf && eLast_reg && fLast_reg && !autoRe) begin
        prio_reg[dma_pkg::P_EN + int'(cur_reg)] <= 1'b0;
      end
      if (gWr(dma_pkg::G_PRIO_CTRL)) prio_reg <= wmerge(prio_reg, wbDatI, wbSel);
    end
  end

  // ==========================================
  // channel interrupts
  logic irqWant;
  always_comb begin
    irqWant = 1'b0;
    if (curMode[dma_pkg::M_ABU]) begin
      irqWant = (eLast_reg & fLast_reg) | (curMode[dma_pkg::M_GRAN] & halfHit_reg);
    end else if (curMode[dma_pkg::M_GRAN]) begin
      irqWant = eLast_reg;
    end else begin
      irqWant = eLast_reg & fLast_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      chanIrq_reg <= '0;
    end else begin
      chanIrq_reg <= '0;
      if (wrDone && finalHalf && curMode[dma_pkg::M_IRQ_EN] && irqWant) begin
        chanIrq_reg[cur_reg] <= 1'b1;
      end
    end
  end
  assign chanIrq = chanIrq_reg;

  // shared lines
  always_comb begin
    irqLines = '{line6: serialIrq[3], line7: serialIrq[2],
                 line10: serialIrq[1], line11: serialIrq[0]};
    case (prio_reg[dma_pkg::P_LSEL +: 2])
      dma_pkg::LSEL_HALF: begin
        irqLines.line10 = chanIrq_reg[2];
        irqLines.line11 = chanIrq_reg[3];
      end
      dma_pkg::LSEL_ALL: begin
        irqLines = '{line6: chanIrq_reg[0], line7: chanIrq_reg[1],
                     line10: chanIrq_reg[2], line11: chanIrq_reg[3]};
      end
      default: begin
      end
    endcase
  end

  // ==========================================
  // wishbone read and ack
  logic [15:0] rdVal;
  always_comb begin
    rdVal = dma_pkg::RST16;
    if (isCh) begin
      case (fld)
        dma_pkg::F_SRC: rdVal = srcAddr_reg[wch];
        dma_pkg::F_DST: rdVal = dstAddr_reg[wch];
        dma_pkg::F_ELEM: rdVal = elementCount_reg[wch];
        dma_pkg::F_SYNC_FRM: rdVal = syncFrame_reg[wch];
        dma_pkg::F_MODE: rdVal = 16'(mode_reg[wch]);
        default: rdVal = dma_pkg::RST16;
      endcase
    end else if (chSel == dma_pkg::CH_GLOBAL) begin
      case (fld)
        dma_pkg::G_ELEM_ADJ0: rdVal = elemAdj0_reg;
        dma_pkg::G_ELEM_ADJ1: rdVal = elemAdj1_reg;
        dma_pkg::G_FRM_ADJ0: rdVal = frmAdj0_reg;
        dma_pkg::G_FRM_ADJ1: rdVal = frmAdj1_reg;
        dma_pkg::G_CNT_RELOAD: rdVal = globalCountReload_reg;
        dma_pkg::G_FRM_RELOAD: rdVal = globalFrameReload_reg;
        dma_pkg::G_PRIO_CTRL: rdVal = prio_reg;
        default: rdVal = dma_pkg::RST16;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wbAck_reg <= 1'b0;
      wbDatO_reg <= '0;
    end else begin
      wbAck_reg <= wbHit;
      if (wbHit && !wbWe) wbDatO_reg <= {16'h0000, rdVal};
    end
  end
  assign wbAck = wbAck_reg;
  assign wbDatO = wbDatO_reg;
  assign memReq = memReq_reg;
  assign memCmd = memCmd_reg;

  // ==========================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence rdAck_s;
    rdDone && finalHalf;
  endsequence

  sequence wrEnd_s;
    wrDone && finalHalf;
  endsequence

  wbAckOnce_a: assert property (wbHit |=> wbAck ##1 !wbAck)
    else $error("wishbone ack not a single pulse");
  memHold_a: assert property (memReq && !memAck |=> memReq && $stable(memCmd))
    else $error("memory request dropped or changed before ack");
  elemDec_a: assert property (rdAck_s ##0 !isFinal |=>
    elementCount_reg[$past(cur_reg)] == 16'($past(curElem) - dma_pkg::ONE16))
    else $error("element counter did not drop by one");
  frameDec_a: assert property (rdAck_s ##0 (isFinal && !lastFrame) |=>
    syncFrame_reg[$past(cur_reg)][7:0] ==
      8'($past(syncFrame_reg[cur_reg][7:0]) - dma_pkg::ONE8))
    else $error("frame counter did not drop at frame end");
  autoReload_a: assert property (rdAck_s ##0 (isFinal && lastFrame && autoRe &&
    !wbWr) |=> elementCount_reg[$past(cur_reg)] == $past(globalCountReload_reg))
    else $error("element counter not reloaded at block end");
  irqEnable_a: assert property (wrEnd_s ##0 !curMode[dma_pkg::M_IRQ_EN] |=>
    chanIrq == '0)
    else $error("interrupt raised while disabled");
  blockIrq_a: assert property (wrEnd_s ##0 (curMode[dma_pkg::M_IRQ_EN] &&
    !curMode[dma_pkg::M_ABU] && !curMode[dma_pkg::M_GRAN] && !fLast_reg) |=> chanIrq == '0)
    else $error("granularity zero interrupted before block end");
  syncWait_a: assert property (start &&
    syncFrame_reg[pick][dma_pkg::SF_SYNC +: 4] != dma_pkg::SYNC_NONE |-> pend_reg[pick])
    else $error("transfer started without its sync event");
  lineReset_a: assert property (prio_reg[dma_pkg::P_LSEL +: 2] == dma_pkg::LSEL_SERIAL |->
    irqLines == serialIrq)
    else $error("serial interrupts not on shared lines");
  dwordPair_a: assert property (wrDone && dword && !half_reg |=>
    state_reg == ST_RD && half_reg)
    else $error("double word second half not issued");
endmodule

// *** dv/mem_model.sv ***
// far-side memory model answering the engine's requests
module mem_model (
  // clock
  input wire logic clock,
  // request and answer
  input wire logic memReq,
  input wire dma_pkg::mem_req_t memCmd,
  output logic memAck,
  output logic [15:0] memRData,
  // answer speed
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [256];
  logic [1:0] waitReg = 2'h0;
  initial begin
    memAck = 1'b0;
    memRData = 16'h0000;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'ha500 ^ 16'(i);
    end
  end
  // ==========================================
  // answer after zero or three wait cycles
  always @(posedge clock) begin
    if (memReq && !memAck && waitReg == {slow, slow}) begin
      memAck <= 1'b1;
      memRData <= mem[memCmd.addr[7:0]];
    end else begin
      memAck <= 1'b0;
      memRData <= ~memRData;
    end
    waitReg <= (memReq && !memAck) ? waitReg + 2'h1 : 2'h0;
    if (memReq && memAck && memCmd.we) begin
      mem[memCmd.addr[7:0]] <= memCmd.wdata;
    end
  end
endmodule

// *** dv/dma_channel_count_index_irq_tb_top.sv ***
// bench for the six-channel dma engine
module dma_channel_count_index_irq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // signals
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, memReq, memAck;
  logic timerEvt = 1'b0, slow = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatI = 32'h0, wbDatO, q;
  logic [15:0] memRData;
  logic [5:0] chanIrq;
  logic [3:0] serialIrq = 4'ha;
  dma_pkg::mem_req_t memCmd;
  dma_pkg::irq_lines_t irqLines;
  int fails = 0, compares = 0;
  dma_channel_count_index_irq uut (.clock(clock), .rst_b(rst_b), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(4'h3), .wbDatI(wbDatI),
    .wbDatO(wbDatO), .wbAck(wbAck), .memReq(memReq), .memCmd(memCmd),
    .memAck(memAck), .memRData(memRData), .serialEvt(6'h00), .timerEvt(timerEvt),
    .extIrq3Pin(1'b0), .serialIrq(serialIrq), .irqLines(irqLines), .chanIrq(chanIrq));
  mem_model far (.clock(clock), .memReq(memReq), .memCmd(memCmd), .memAck(memAck),
    .memRData(memRData), .slow(slow));
  initial begin
    forever #2.5 clock = ~clock;
  end
  // ==========================================
  // checking and bus tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
    int n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= {16'h0000, d};
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    bound(n, 20);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clock);
  endtask
  // ==========================================
  // scenarios
  task automatic lines();
    logic [3:0] e [4] = '{4'ha, 4'h8, 4'h0, 4'ha};
    chk("resetLines", irqLines, 4'ha);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 8'h18, {2'(i), 14'h0000});
      chk("lineMux", irqLines, e[i]);
    end
  endtask
  task automatic run(input logic [15:0] mode, input int pulses, input int reqs);
    int n = 0, p = 0, r = 0;
    logic [15:0] src [4] = '{16'h0010, 16'h0012, 16'h0017, 16'h0019};
    wb(1'b1, 8'ha0, 16'h0010);
    wb(1'b1, 8'ha4, 16'h0040);
    wb(1'b1, 8'ha8, 16'h0001);
    wb(1'b1, 8'hac, 16'h0001);
    wb(1'b1, 8'hb0, mode);
    wb(1'b1, 8'h18, 16'h0010);
    do begin
      @(posedge clock);
      n++;
      r += (memAck === 1'b1);
      p += (chanIrq[4] === 1'b1);
    end while (r < reqs && n < 400);
    bound(n, 400);
    repeat (3) begin
      @(posedge clock);
      p += (chanIrq[4] === 1'b1);
    end
    chk("irqPulses", p, pulses);
    for (int i = 0; i < 4 && !mode[3]; i++) begin
      chk("dstWord", far.mem[8'h40 + i], 16'ha500 ^ src[i]);
    end
  endtask
  task automatic synced();
    int n = 0;
    wb(1'b1, 8'hc8, 16'h0000);
    wb(1'b1, 8'hcc, 16'hd000);
    wb(1'b1, 8'hd0, 16'h0002);
    wb(1'b1, 8'h18, 16'h0020);
    repeat (30) begin
      @(posedge clock);
      chk("earlyReq", memReq, 1'b0);
    end
    timerEvt <= 1'b1;
    @(posedge clock);
    timerEvt <= 1'b0;
    do begin
      @(posedge clock);
      n++;
    end while (chanIrq[5] !== 1'b1 && n < 60);
    bound(n, 60);
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    lines();
    wb(1'b1, 8'h00, 16'h0002);
    wb(1'b1, 8'h08, 16'h0005);
    run(16'h0182, 1, 8);
    slow <= 1'b1;
    run(16'h0186, 2, 8);
    slow <= 1'b0;
    run(16'h018a, 1, 16);
    run(16'h0180, 0, 8);
    wb(1'b1, 8'h10, 16'h0007);
    wb(1'b1, 8'h14, 16'h0003);
    run(16'h0183, 1, 8);
    wb(1'b1, 8'h18, 16'h0000);
    wb(1'b0, 8'hac, 16'h0000);
    chk("frameReload", q, 32'h3);
    run(16'h0196, 2, 8);
    wb(1'b1, 8'h18, 16'h0000);
    synced();
    print_verdict();
  end
endmodule
